// ---- obx_top.sv ----
`timescale 1ns/1ps

module obx_top #(
	parameter int          STEP_TICKS    = obx_pkg::STEP_TICKS,
	parameter logic [2:0]  CHANNEL_NUM   = 3'h1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	input  wire logic         mode_strap_n,
	input  wire logic         power_clear_ok,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic              pready,
	output logic [31:0]       prdata,
	output logic              pslverr,
	output logic [11:0]       voltage_setpoint_converter,
	output logic [11:0]       readback_converter,
	output logic [7:0]        current_limit_converter,
	output logic [7:0]        overvoltage_setpoint_converter,
	output logic [2:0]        readback_mux_sel,
	output logic              prog_overvoltage_inhibit,
	output logic              hardware_fault_banner,
	output logic [2:0]        banner_channel,
	output logic              selftest_fail
);

	obx_pkg::obx_state_e state;
	obx_ramp_if          rif ();
	obx_reg_if           rg ();

	logic        strap_s1, strap_s2, clr_s1, clr_s2;
	logic [1:0]  strap_cnt;
	logic        exer_mode;
	logic [3:0]  tick_cnt;
	logic        tick;
	logic [15:0] step_cnt;
	logic        step;
	logic [1:0]  conv_idx;
	logic [3:0]  loop_count;
	logic [3:0]  test_idx;
	logic [7:0]  rom_acc;
	logic        tests_pass;
	logic [7:0]  ram [obx_pkg::RAM_WORDS];
	logic [11:0] host_vset, host_rbset;
	logic [7:0]  host_iset, host_ovset;
	logic [2:0]  host_mux;

	function automatic logic [7:0] ram_pattern(input logic [3:0] idx);
		ram_pattern = {4'h0, idx} ^ obx_pkg::RAM_SEED;
	endfunction

	function automatic logic [7:0] rom_word(input logic [3:0] idx);
		rom_word = 8'({4'h0, idx} * obx_pkg::ROM_MULT) + obx_pkg::ROM_ADD;
	endfunction

	function automatic logic [3:0] conv_width(input logic [1:0] idx);
		conv_width = idx[1] ? obx_pkg::NARROW_W : obx_pkg::WIDE_W;
	endfunction

	obx_ramp u_ramp (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.rif     (rif)
	);

	obx_apb u_apb (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pready  (pready),
		.prdata  (prdata),
		.pslverr (pslverr),
		.regs    (rg)
	);

	assign rif.step  = step && state == obx_pkg::ST_EXER;
	assign rif.width = conv_width(conv_idx);
	assign rif.clear = state != obx_pkg::ST_EXER;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			strap_s1 <= 1'b1;
			strap_s2 <= 1'b1;
			clr_s1   <= 1'b0;
			clr_s2   <= 1'b0;
		end
		else if (ce)
		begin
			strap_s1 <= mode_strap_n;
			strap_s2 <= strap_s1;
			clr_s1   <= power_clear_ok;
			clr_s2   <= clr_s1;
		end
	end

	// ****************************************
	// 4 MHz tick and step interval
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tick_cnt <= 4'h0;
			tick     <= 1'b0;
		end
		else if (ce)
		begin
			tick     <= tick_cnt == 4'(obx_pkg::TICK_DIV - 1);
			tick_cnt <= (tick_cnt == 4'(obx_pkg::TICK_DIV - 1)) ? 4'h0 : tick_cnt + 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			step_cnt <= 16'h0000;
			step     <= 1'b0;
		end
		else if (ce)
		begin
			step <= 1'b0;
			if (state != obx_pkg::ST_EXER)
				step_cnt <= 16'h0000;
			else if (tick)
			begin
				if (step_cnt == 16'(STEP_TICKS - 1))
				begin
					step_cnt <= 16'h0000;
					step     <= 1'b1;
				end
				else
					step_cnt <= step_cnt + 16'h0001;
			end
		end
	end

	// ****************************************
	// Mode sequencer
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state      <= obx_pkg::ST_STRAP;
			strap_cnt  <= 2'h0;
			exer_mode  <= 1'b0;
			test_idx   <= 4'h0;
			rom_acc    <= 8'h00;
			tests_pass <= 1'b0;
		end
		else if (ce)
		begin
			case (state)
				obx_pkg::ST_STRAP:
				begin
					// Strap is caught once, after the synchroniser has filled
					if (strap_cnt == 2'(obx_pkg::STRAP_SETTLE))
					begin
						exer_mode <= !strap_s2;
						state     <= strap_s2 ? obx_pkg::ST_NORMAL : obx_pkg::ST_WAIT_CLEAR;
					end
					else
						strap_cnt <= strap_cnt + 2'h1;
				end
				obx_pkg::ST_WAIT_CLEAR:
				begin
					test_idx <= 4'h0;
					rom_acc  <= 8'h00;
					tests_pass <= 1'b0;
					if (clr_s2)
						state <= obx_pkg::ST_RAM_WR;
				end
				obx_pkg::ST_RAM_WR:
				begin
					test_idx <= test_idx + 4'h1;
					if (test_idx == 4'hf)
						state <= obx_pkg::ST_RAM_RD;
				end
				obx_pkg::ST_RAM_RD:
				begin
					test_idx <= test_idx + 4'h1;
					if (ram[test_idx] != ram_pattern(test_idx))
						state <= obx_pkg::ST_FAIL;
					else if (test_idx == 4'hf)
						state <= obx_pkg::ST_ROM;
				end
				obx_pkg::ST_ROM:
				begin
					test_idx <= test_idx + 4'h1;
					rom_acc  <= rom_acc + rom_word(test_idx);
					if (test_idx == 4'hf)
					begin
						tests_pass <= (rom_acc + rom_word(test_idx)) == obx_pkg::ROM_SUM;
						state      <= ((rom_acc + rom_word(test_idx)) == obx_pkg::ROM_SUM)
							? obx_pkg::ST_EXER : obx_pkg::ST_FAIL;
					end
				end
				obx_pkg::ST_EXER:
				begin
					if (!clr_s2)
						state <= obx_pkg::ST_WAIT_CLEAR;
				end
				obx_pkg::ST_NORMAL:
					state <= obx_pkg::ST_NORMAL;
				obx_pkg::ST_FAIL:
				begin
					if (!clr_s2)
						state <= obx_pkg::ST_WAIT_CLEAR;
				end
				default:
					state <= obx_pkg::ST_STRAP;
			endcase
		end
	end

	always_ff @(posedge pclk)
	begin
		if (ce && state == obx_pkg::ST_RAM_WR)
			ram[test_idx] <= ram_pattern(test_idx);
	end

	// ****************************************
	// Converter walk order and loop count
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			conv_idx   <= 2'h0;
			loop_count <= 4'h0;
		end
		else if (ce)
		begin
			if (state != obx_pkg::ST_EXER)
				conv_idx <= 2'h0;
			else if (rif.done)
			begin
				conv_idx <= conv_idx + 2'h1;
				if (conv_idx == 2'h3)
					loop_count <= loop_count + 4'h1;
			end
		end
	end

	// ****************************************
	// Host registers; exercise locks them out
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			host_vset  <= obx_pkg::WIDE_RESET;
			host_rbset <= obx_pkg::WIDE_RESET;
			host_iset  <= obx_pkg::NARROW_RESET;
			host_ovset <= obx_pkg::NARROW_RESET;
			host_mux   <= obx_pkg::MUX_RESET;
		end
		else if (rg.wr && !exer_mode)
		begin
			case (rg.addr)
				obx_pkg::ADDR_VSET:  host_vset  <= rg.wdata[11:0];
				obx_pkg::ADDR_ISET:  host_iset  <= rg.wdata[7:0];
				obx_pkg::ADDR_OVSET: host_ovset <= rg.wdata[7:0];
				obx_pkg::ADDR_RBSET: host_rbset <= rg.wdata[11:0];
				obx_pkg::ADDR_MUX:   host_mux   <= rg.wdata[2:0];
				default:             host_mux   <= host_mux;
			endcase
		end
	end

	always_comb
	begin
		rg.hit   = 1'b1;
		rg.rdata = 32'h0000_0000;
		case (rg.addr)
			obx_pkg::ADDR_VSET:  rg.rdata[11:0] = host_vset;
			obx_pkg::ADDR_ISET:  rg.rdata[7:0]  = host_iset;
			obx_pkg::ADDR_OVSET: rg.rdata[7:0]  = host_ovset;
			obx_pkg::ADDR_RBSET: rg.rdata[11:0] = host_rbset;
			obx_pkg::ADDR_MUX:   rg.rdata[2:0]  = host_mux;
			obx_pkg::ADDR_STATUS:
			begin
				rg.rdata[obx_pkg::ST_BIT_EXER] = exer_mode;
				rg.rdata[obx_pkg::ST_BIT_PASS] = tests_pass;
				rg.rdata[obx_pkg::ST_BIT_FAIL] = state == obx_pkg::ST_FAIL;
				rg.rdata[obx_pkg::ST_BIT_RUN]  = state == obx_pkg::ST_EXER;
				rg.rdata[obx_pkg::ST_LOOP_LSB +: 4] = loop_count;
			end
			default:             rg.hit = 1'b0;
		endcase
	end

	// ****************************************
	// Converter, mux and display outputs
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			voltage_setpoint_converter     <= obx_pkg::WIDE_RESET;
			readback_converter             <= obx_pkg::WIDE_RESET;
			current_limit_converter        <= obx_pkg::NARROW_RESET;
			overvoltage_setpoint_converter <= obx_pkg::NARROW_RESET;
			readback_mux_sel               <= obx_pkg::MUX_RESET;
		end
		else if (ce)
		begin
			if (state == obx_pkg::ST_EXER)
			begin
				case (conv_idx)
					2'h0:    voltage_setpoint_converter     <= rif.code;
					2'h1:    readback_converter             <= rif.code;
					2'h2:    current_limit_converter        <= rif.code[7:0];
					default: overvoltage_setpoint_converter <= rif.code[7:0];
				endcase
				if (step)
					readback_mux_sel <= (readback_mux_sel == obx_pkg::MUX_COMMON)
						? obx_pkg::MUX_VSENSE : obx_pkg::MUX_COMMON;
			end
			else if (!exer_mode)
			begin
				voltage_setpoint_converter     <= host_vset;
				readback_converter             <= host_rbset;
				current_limit_converter        <= host_iset;
				overvoltage_setpoint_converter <= host_ovset;
				readback_mux_sel               <= host_mux;
			end
			else
			begin
				// Outside the loop the converters rest at zero and the mux at common so no load is driven
				voltage_setpoint_converter     <= obx_pkg::WIDE_RESET;
				readback_converter             <= obx_pkg::WIDE_RESET;
				current_limit_converter        <= obx_pkg::NARROW_RESET;
				overvoltage_setpoint_converter <= obx_pkg::NARROW_RESET;
				readback_mux_sel               <= obx_pkg::MUX_COMMON;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prog_overvoltage_inhibit <= 1'b0;
			hardware_fault_banner    <= 1'b0;
			banner_channel           <= 3'h0;
			selftest_fail            <= 1'b0;
		end
		else if (ce)
		begin
			prog_overvoltage_inhibit <= exer_mode;
			hardware_fault_banner    <= exer_mode;
			banner_channel           <= exer_mode ? CHANNEL_NUM : 3'h0;
			selftest_fail            <= state == obx_pkg::ST_FAIL;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	AST_INHIBIT_HELD: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && exer_mode) |=> prog_overvoltage_inhibit)
		else $error("Overvoltage inhibit low during exercise");
	AST_BANNER_CH: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && exer_mode) |=> hardware_fault_banner && banner_channel == CHANNEL_NUM)
		else $error("Fault banner missing during exercise");
	AST_NORMAL_START: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && state == obx_pkg::ST_STRAP && strap_cnt == 2'h2 && strap_s2)
		|=> state == obx_pkg::ST_NORMAL && !exer_mode)
		else $error("High strap did not start normally");
	AST_WAIT_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && state == obx_pkg::ST_WAIT_CLEAR && !clr_s2)
		|=> state == obx_pkg::ST_WAIT_CLEAR)
		else $error("Left wait without power clear");
	AST_HOST_LOCKED: assert property (@(posedge pclk) disable iff (!presetn)
		(rg.wr && exer_mode) |=> $stable(host_vset) && $stable(host_mux))
		else $error("Host write took effect during exercise");
	AST_MUX_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && state == obx_pkg::ST_EXER && step && readback_mux_sel == obx_pkg::MUX_COMMON)
		|=> readback_mux_sel == obx_pkg::MUX_VSENSE)
		else $error("Readback mux did not switch to sense input");
	AST_TICK_RATE: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && tick) |=> (!(ce && tick)) [*8])
		else $error("Oscillator tick faster than 4 MHz");
	AST_EXIT_ON_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && state == obx_pkg::ST_EXER && !clr_s2) |=> state == obx_pkg::ST_WAIT_CLEAR)
		else $error("Loop kept running after power clear dropped");

	COV_EXER: cover property (@(posedge pclk) disable iff (!presetn)
		state == obx_pkg::ST_EXER);
	COV_FULL_SCALE: cover property (@(posedge pclk) disable iff (!presetn)
		voltage_setpoint_converter == 12'hfff);
	COV_LOOP_WRAP: cover property (@(posedge pclk) disable iff (!presetn)
		rif.done && conv_idx == 2'h3);

endmodule

// ---- obx_pkg.sv ----
package obx_pkg;

	// ****************************************
	// Clocking and timing
	// ****************************************
	localparam int PCLK_FREQ_KHZ  = 40000;
	localparam int OSC_FREQ_KHZ   = 4000;
	localparam int TICK_DIV       = PCLK_FREQ_KHZ / OSC_FREQ_KHZ;
	localparam int STEP_TIME_US   = 250;
	localparam int STEP_TICKS     = STEP_TIME_US * OSC_FREQ_KHZ / 1000;
	localparam int STRAP_SETTLE   = 2;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_VSET   = 8'h00;
	localparam logic [7:0] ADDR_ISET   = 8'h04;
	localparam logic [7:0] ADDR_OVSET  = 8'h08;
	localparam logic [7:0] ADDR_RBSET  = 8'h0c;
	localparam logic [7:0] ADDR_MUX    = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;

	// Status field positions
	localparam int ST_BIT_EXER    = 0;
	localparam int ST_BIT_PASS    = 1;
	localparam int ST_BIT_FAIL    = 2;
	localparam int ST_BIT_RUN     = 3;
	localparam int ST_LOOP_LSB    = 8;

	// ****************************************
	// Widths, codes and reset values
	// ****************************************
	localparam int WIDE_BITS      = 12;
	localparam int NARROW_BITS    = 8;
	localparam logic [3:0] WIDE_W   = 4'hc;
	localparam logic [3:0] NARROW_W = 4'h8;
	localparam logic [2:0] MUX_COMMON = 3'h1;
	localparam logic [2:0] MUX_VSENSE = 3'h3;
	localparam logic [2:0] MUX_RESET  = 3'h1;
	localparam logic [11:0] WIDE_RESET   = 12'h000;
	localparam logic [7:0]  NARROW_RESET = 8'h00;
	localparam int RAM_WORDS      = 16;
	localparam logic [7:0] RAM_SEED  = 8'h55;
	localparam logic [7:0] ROM_MULT  = 8'h25;
	localparam logic [7:0] ROM_ADD   = 8'h05;
	localparam logic [7:0] ROM_SUM   = 8'ha8;

	typedef enum logic [2:0] {
		ST_STRAP,
		ST_WAIT_CLEAR,
		ST_RAM_WR,
		ST_RAM_RD,
		ST_ROM,
		ST_EXER,
		ST_NORMAL,
		ST_FAIL
	} obx_state_e;

endpackage

// ---- obx_if.sv ----
`timescale 1ns/1ps

interface obx_ramp_if;
	logic        step;
	logic [3:0]  width;
	logic [11:0] code;
	logic        done;
	logic        clear;
	modport ctrl (output step, output width, output clear, input code, input done);
	modport ramp (input step, input width, input clear, output code, output done);
endinterface

interface obx_reg_if;
	logic        wr;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        hit;
	modport slave (output wr, output addr, output wdata, input rdata, input hit);
	modport core  (input wr, input addr, input wdata, output rdata, output hit);
endinterface

// ---- obx_ramp.sv ----
`timescale 1ns/1ps

module obx_ramp (
	input  wire logic   pclk,
	input  wire logic   presetn,
	input  wire logic   ce,
	obx_ramp_if.ramp    rif
);

	logic        going_down;
	logic [11:0] mask;

	always_comb
	begin
		mask = 12'hfff >> (4'hc - rif.width);
	end

	// ****************************************
	// Bit walk: set from the LSB up, then clear from the LSB up
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rif.code   <= 12'h000;
			going_down <= 1'b0;
			rif.done   <= 1'b0;
		end
		else if (ce)
		begin
			rif.done <= 1'b0;
			if (rif.clear)
			begin
				// Leaving the loop restarts the next walk from zero
				rif.code   <= 12'h000;
				going_down <= 1'b0;
			end
			else if (rif.step)
			begin
				if (!going_down)
				begin
					if (rif.code == mask)
					begin
						going_down <= 1'b1;
						rif.code   <= {rif.code[10:0], 1'b0} & mask;
					end
					else
						rif.code <= {rif.code[10:0], 1'b1} & mask;
				end
				else
				begin
					rif.code <= {rif.code[10:0], 1'b0} & mask;
					if (({rif.code[10:0], 1'b0} & mask) == 12'h000)
					begin
						going_down <= 1'b0;
						rif.done   <= 1'b1;
					end
				end
			end
		end
	end

	AST_RAMP_UP: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && rif.step && !going_down && rif.code != mask)
		|=> rif.code == (({$past(rif.code[10:0]), 1'b1}) & mask))
		else $error("Upward walk did not set the next bit");
	AST_RAMP_DOWN: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && rif.step && (going_down || rif.code == mask))
		|=> rif.code == (({$past(rif.code[10:0]), 1'b0}) & mask))
		else $error("Downward walk did not clear the lowest set bit");

endmodule

// ---- obx_apb.sv ----
`timescale 1ns/1ps

module obx_apb (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	obx_reg_if.slave         regs
);

	assign regs.addr  = paddr;
	assign regs.wdata = pwdata;
	// Write lands only at the edge where the master sees pready
	assign regs.wr    = ce && psel && penable && pready && pwrite && regs.hit;

	// ****************************************
	// One wait-free access; answers come from flops
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (ce)
		begin
			if (psel && !penable && !pready)
			begin
				pready  <= 1'b1;
				prdata  <= regs.hit ? regs.rdata : 32'h0000_0000;
				pslverr <= !regs.hit;
			end
			else
			begin
				pready  <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end

endmodule

// ---- obx_partner.sv ----
`timescale 1ns/1ps

// ****************************************
// Far side: the four converters only
// ****************************************
// Passive like the real converters: it only counts code changes per converter.
module obx_partner (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] vset,
	input  wire logic [11:0] rbset,
	input  wire logic [7:0]  iset,
	input  wire logic [7:0]  ovset,
	output int               n_steps [4]
);
	logic [39:0] cur;
	logic [39:0] last;

	assign cur = {ovset, iset, rbset, vset};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			n_steps <= '{4{0}};
			last    <= '0;
		end
		else
		begin
			last <= cur;
			if (cur[11:0] != last[11:0])
				n_steps[0] <= n_steps[0] + 1;
			if (cur[23:12] != last[23:12])
				n_steps[1] <= n_steps[1] + 1;
			if (cur[31:24] != last[31:24])
				n_steps[2] <= n_steps[2] + 1;
			if (cur[39:32] != last[39:32])
				n_steps[3] <= n_steps[3] + 1;
		end
	end
endmodule

// ---- tb_output_board_self_exercise.sv ----
`timescale 1ns/1ps

module tb_output_board_self_exercise;
	// ****************************************
	// Setup
	// ****************************************
	// Short step so a full loop takes only about 1600 cycles
	localparam int         STEP = 2;
	localparam int         GAP  = STEP * obx_pkg::TICK_DIV;
	localparam logic [2:0] CHAN = 3'h5;
	logic        pclk, presetn, ce, mode_strap_n, power_clear_ok;
	logic        psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, wv;
	logic [11:0] vconv, rbconv;
	logic [7:0]  iconv, ovconv;
	logic [2:0]  mux, chan, last_mux;
	logic        inhibit, banner, fail;
	int          bad_count, n_compared, seed, n_steps [4];
	logic [31:0] masks [5] = '{32'hfff, 32'hff, 32'hff, 32'hfff, 32'h7};

	obx_top #(.STEP_TICKS(STEP), .CHANNEL_NUM(CHAN)) DUT (
		.pclk(pclk), .presetn(presetn), .ce(ce), .mode_strap_n(mode_strap_n),
		.power_clear_ok(power_clear_ok), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.voltage_setpoint_converter(vconv), .readback_converter(rbconv),
		.current_limit_converter(iconv), .overvoltage_setpoint_converter(ovconv),
		.readback_mux_sel(mux), .prog_overvoltage_inhibit(inhibit),
		.hardware_fault_banner(banner), .banner_channel(chan), .selftest_fail(fail));

	obx_partner far_side (.pclk(pclk), .presetn(presetn), .vset(vconv), .rbset(rbconv),
		.iset(iconv), .ovset(ovconv), .n_steps(n_steps));

	initial
	begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic finish_test();
		$display("compares %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic check_cnt(input int got, input int exp);
		check_val(32'(got), 32'(exp));
	endtask

	function automatic logic [31:0] exp_code(input int w, input int n);
		logic [11:0] ones;
		ones = 12'hfff >> (12 - w);
		if (n <= w)
			return 32'(ones >> (w - n));
		return 32'((ones << (n - w)) & ones);
	endfunction

	function automatic logic [31:0] conv(input int i);
		case (i)
			0: return 32'(vconv);
			1: return 32'(rbconv);
			2: return 32'(iconv);
			3: return 32'(ovconv);
			default: return 32'(mux);
		endcase
	endfunction

	// Host order differs from walk order: voltage, current, overvoltage, readback, mux
	function automatic int host_idx(input int j);
		int map [5] = '{0, 2, 3, 1, 4};
		return map[j];
	endfunction

	task automatic do_reset(input logic strap);
		presetn      <= 1'b0;
		mode_strap_n <= strap;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Waits for the answer; only the watchdog ends a hang
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Idle edge so a following call never re-drives psel in this time step
		@(posedge pclk);
	endtask

	// Follows one converter through its up and down walk, step by step
	task automatic follow(input int i, input int w);
		logic [31:0] prev;
		int t;
		for (int n = 1; n <= 2 * w; n++)
		begin
			prev = conv(i);
			t = 0;
			while (conv(i) === prev && t < 400)
			begin
				@(posedge pclk);
				t++;
			end
			check_val(conv(i), exp_code(w, n));
			if (n > 1)
				check_cnt(t, GAP);
			if (last_mux !== 3'h0)
				check_val(32'(mux), (last_mux == 3'h1) ? 32'h3 : 32'h1);
			last_mux = mux;
			check_val(32'(inhibit), 32'h1);
		end
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{bad_count, n_compared} = '0;
		seed = 81;
		ce = 1'b1;
		presetn = 1'b0;
		mode_strap_n = 1'b1;
		power_clear_ok = 1'b0;
		last_mux = 3'h0;
		do_reset(1'b1);
		// Normal mode runs without power clear
		for (int k = 0; k < 6; k++)
			for (int j = 0; j < 5; j++)
			begin
				wv = $random(seed);
				apb(1'b1, 8'(j * 4), wv, rd, err);
				apb(1'b0, 8'(j * 4), 32'h0, rd, err);
				check_val(rd, wv & masks[j]);
				check_val(conv(host_idx(j)), wv & masks[j]);
			end
		apb(1'b0, 8'h40, 32'h0, rd, err);
		check_val({rd[30:0], err}, 32'h1);
		apb(1'b0, obx_pkg::ADDR_STATUS, 32'h0, rd, err);
		check_val(rd[0], 32'h0);
		check_val({27'h0, chan, inhibit, banner}, 32'h0);
		$display("normal mode test done");

		do_reset(1'b0);
		repeat (40) @(posedge pclk);
		apb(1'b0, obx_pkg::ADDR_STATUS, 32'h0, rd, err);
		check_val({rd[3], rd[0]}, 32'h1);
		apb(1'b1, obx_pkg::ADDR_VSET, 32'hfff, rd, err);
		apb(1'b1, obx_pkg::ADDR_ISET, 32'hff, rd, err);
		repeat (3) @(posedge pclk);
		check_val({vconv, iconv}, 32'h0);
		check_val({banner, chan}, {28'h0, 1'b1, CHAN});
		check_val(32'(inhibit), 32'h1);
		power_clear_ok <= 1'b1;
		for (int l = 0; l < 2; l++)
		begin
			follow(0, 12);
			follow(1, 12);
			follow(2, 8);
			follow(3, 8);
		end
		// The far side counts a change one edge after it appears
		repeat (2) @(posedge pclk);
		for (int i = 0; i < 4; i++)
			check_cnt(n_steps[i], (i < 2) ? 48 : 32);
		apb(1'b0, obx_pkg::ADDR_STATUS, 32'h0, rd, err);
		check_val({rd[2:1], fail}, 32'h2);
		// Clock enable low must freeze the walk across a whole step
		ce <= 1'b0;
		@(posedge pclk);
		wv = {vconv, rbconv, iconv};
		rd = {21'h0, ovconv, mux};
		repeat (30) @(posedge pclk);
		check_val({vconv, rbconv, iconv}, wv);
		check_val({21'h0, ovconv, mux}, rd);
		ce <= 1'b1;
		$display("exercise loop test done");

		power_clear_ok <= 1'b0;
		repeat (10) @(posedge pclk);
		check_val({vconv, rbconv, iconv}, 32'h0);
		check_val({ovconv, mux}, 32'h1);
		power_clear_ok <= 1'b1;
		last_mux = 3'h0;
		follow(0, 12);
		$display("power clear restart test done");
		finish_test();
	end

	initial
	begin
		#(25 * 20000);
		bad_count++;
		finish_test();
	end
endmodule
